// ### flash_adc_defs.svh
// Summary of operation
// - 256 comparators against equally spaced ladder taps
// - comparators track the input while clock low
// - rising edge holds decisions as thermometer code
// - falling edge registers four 64-to-7 column decoders
// - decoders feed four 7-bit column latches
// - selected column gives low bits, index high bits
// - eight XOR gates apply both inversion controls
// - no inversion: top all ones, bottom zeros
// - inversion controls default low when untouched
// - output latches hold the final 8 bits
// - result appears one conversion clock after sampling
// - overrange raises flag and forces data high
// - ready strobe delayed to match the pipeline
// - polarity select inverts the ready strobe
// - metastable comparator costs at most one code step
// - low invert control touches bits 0 to 6
// - msb invert control touches bit 7 only
`ifndef FLASH_ADC_DEFS_SVH
`define FLASH_ADC_DEFS_SVH

// converter geometry
`define NUM_COMP        256
`define COL_SIZE        64
`define NUM_COL         4
`define IN_WIDTH        9
`define COL_WIDTH       7

// register byte offsets
`define CTRL_OFS        4'h0
`define STATUS_OFS      4'h4
`define MASK_OFS        4'h8
`define RESULT_OFS      4'hC

// control fields
`define CTRL_EN_BIT     0
`define CTRL_LOW_INV_BIT 1
`define CTRL_MSB_INV_BIT 2
`define CTRL_POL_BIT    3
`define CTRL_WIDTH      4

// status and mask fields
`define ST_SAMPLE_BIT   0
`define ST_OVER_BIT     1
`define ST_WIDTH        2

// reset values
`define CTRL_RST        4'h0
`define STATUS_RST      2'h0
`define MASK_RST        2'h0

// ref_clk cycles per conversion clock
`define CONV_CYCLES     2

`endif

// ### flash_adc_pkg.sv
package flash_adc_pkg;

  // conversion clock phase, one-hot
  typedef enum logic [1:0] {
    PH_TRACK = 2'b01,
    PH_HOLD  = 2'b10
  } conv_phase_t;

  // state of the converter back end, apart from the column latches
  typedef struct packed {
    conv_phase_t  phase;
    logic [8:0]   in_meta;
    logic [8:0]   in_sync;
    logic [255:0] comp;
    logic         comp_ok;
    logic         cols_ok;
    logic [7:0]   plain;
    logic [7:0]   data_out;
    logic         over;
    logic         strobe_lvl;
    logic         strobe_out;
    logic [3:0]   ctrl;
    logic [1:0]   status;
    logic [1:0]   mask;
    logic [1:0]   rd_snap;
    logic         irq;
    logic         waitreq;
    logic [31:0]  rdata;
  } flash_state_t;

  // state of one column decoder
  typedef struct packed {
    logic [6:0] value;
  } column_state_t;

endpackage : flash_adc_pkg

// ### column_decoder.sv
`timescale 1ns/10ps
`include "flash_adc_defs.svh"
module column_decoder
  import flash_adc_pkg::*;
(
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     srst,
  // thermometer slice
  input  wire logic                     load,
  input  wire logic [`COL_SIZE-1:0]     therm,
  // latched column value, bit 6 set when the column is full
  output logic      [`COL_WIDTH-1:0]    value
);

  column_state_t q;
  column_state_t d;
  logic [`COL_WIDTH-1:0] ones;

  // counting ones keeps a lone bubble to one code step
  always_comb begin
    ones = '0;
    for (int i = 0; i < `COL_SIZE; i++) begin
      ones = ones + {6'h00, therm[i]};
    end
    d = q;
    if (load) begin
      d.value = ones;
    end
  end

  // column latch
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign value = q.value;

  // a registered column never exceeds its comparator count
  a_col_bounded: assert property (@(posedge ref_clk) disable iff (srst)
    load |=> value <= 7'h40)
    else $error("column value out of range");

endmodule : column_decoder

// ### flash_adc_output_decode.sv
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "flash_adc_defs.svh"
module flash_adc_output_decode
  import flash_adc_pkg::*;
(
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   srst,
  // avalon-mm slave
  input  wire logic [3:0]             address,
  input  wire logic                   read,
  input  wire logic                   write,
  input  wire logic [31:0]            writedata,
  input  wire logic [3:0]             byteenable,
  output logic      [31:0]            readdata,
  output logic                        waitrequest,
  // sampled input level from the front end
  input  wire logic [`IN_WIDTH-1:0]   analog_input,
  // conversion result
  output logic      [7:0]             result_bits,
  output logic                        overrange_flag,
  output logic                        data_valid_strobe,
  // interrupt
  output logic                        irq
);

  flash_state_t q;
  flash_state_t d;

  localparam flash_state_t STATE_RST = '{
    phase:      PH_TRACK,
    in_meta:    9'h000,
    in_sync:    9'h000,
    comp:       '0,
    comp_ok:    1'b0,
    cols_ok:    1'b0,
    plain:      8'h00,
    data_out:   8'h00,
    over:       1'b0,
    strobe_lvl: 1'b0,
    strobe_out: 1'b0,
    ctrl:       `CTRL_RST,
    status:     `STATUS_RST,
    mask:       `MASK_RST,
    rd_snap:    2'h0,
    irq:        1'b0,
    waitreq:    1'b1,
    rdata:      32'h0000_0000
  };

  logic [`NUM_COMP-1:0]  therm_now;
  logic [`COL_WIDTH-1:0] col_val [`NUM_COL];
  logic                  col_load;
  logic                  ctrl_en;
  logic                  low_bits_invert_ctl;
  logic                  msb_invert_ctl;
  logic                  valid_polarity_sel;
  logic [2:0]            sel;
  logic                  over_raw;
  logic [7:0]            raw;
  logic [7:0]            flip;
  logic                  req;
  logic                  accept;
  logic [31:0]           rd_word;
  logic [1:0]            evt;
  logic [1:0]            clr;
  logic                  latch_evt;

  // control fields, all low after reset
  assign ctrl_en             = q.ctrl[`CTRL_EN_BIT];
  assign low_bits_invert_ctl = q.ctrl[`CTRL_LOW_INV_BIT];
  assign msb_invert_ctl      = q.ctrl[`CTRL_MSB_INV_BIT];
  assign valid_polarity_sel  = q.ctrl[`CTRL_POL_BIT];

  // ladder compare against the tracked input, tap k at level k
  for (genvar k = 0; k < `NUM_COMP; k++) begin : g_ladder
    assign therm_now[k] = (q.in_sync > 9'(k));
  end

  // columns register on the falling phase
  assign col_load = ctrl_en && (q.phase == PH_HOLD) && q.comp_ok;

  // four column decoders over 64 comparators each
  for (genvar c = 0; c < `NUM_COL; c++) begin : g_col
    column_decoder u_col (
      .ref_clk (ref_clk),
      .srst    (srst),
      .load    (col_load),
      .therm   (q.comp[c*`COL_SIZE +: `COL_SIZE]),
      .value   (col_val[c])
    );
  end

  // pick the lowest column that is not full
  always_comb begin
    sel = 3'h4;
    for (int c = `NUM_COL - 1; c >= 0; c--) begin
      if (!col_val[c][6]) begin
        sel = 3'(c);
      end
    end
    over_raw = sel[2];
    if (over_raw) begin
      raw = 8'hFF;
    end else begin
      raw = {sel[1:0], col_val[sel[1:0]][5:0]};
    end
    flip = {msb_invert_ctl, {7{low_bits_invert_ctl}}};
  end

  // bus strobes
  assign req    = read || write;
  assign accept = req && !q.waitreq;

  // register read mux, unmapped offsets read zero
  always_comb begin
    case (address)
      `CTRL_OFS:   rd_word = {28'h0000000, q.ctrl};
      `STATUS_OFS: rd_word = {30'h00000000, q.status};
      `MASK_OFS:   rd_word = {30'h00000000, q.mask};
      `RESULT_OFS: rd_word = {23'h000000, q.over, q.data_out};
      default:     rd_word = 32'h0000_0000;
    endcase
  end

  // next state of the block, apart from the column latches
  always_comb begin
    d         = q;
    latch_evt = 1'b0;
    evt       = 2'h0;
    clr       = 2'h0;
    // two-stage input synchroniser
    d.in_meta = analog_input;
    d.in_sync = q.in_meta;
    // conversion clock phases
    if (!ctrl_en) begin
      d.phase      = PH_TRACK;
      d.comp_ok    = 1'b0;
      d.cols_ok    = 1'b0;
      d.strobe_lvl = 1'b0;
    end else begin
      unique case (q.phase)
        PH_TRACK: begin
          // rising edge: comparators hold the tracked decision
          d.comp    = therm_now;
          d.comp_ok = 1'b1;
          d.phase   = PH_HOLD;
          if (q.cols_ok) begin
            // output latches take the decoded columns
            latch_evt    = 1'b1;
            d.plain      = raw;
            d.over       = over_raw;
            d.data_out   = over_raw ? 8'hFF : (raw ^ flip);
            d.strobe_lvl = 1'b1;
          end
        end
        PH_HOLD: begin
          // falling edge: columns load, strobe returns
          d.cols_ok    = q.comp_ok;
          d.strobe_lvl = 1'b0;
          d.phase      = PH_TRACK;
        end
        default: begin
          d.phase = PH_TRACK;
        end
      endcase
    end
    // bus handshake, one wait cycle per access
    d.waitreq = !(req && q.waitreq);
    if (req && q.waitreq && read) begin
      d.rdata   = rd_word;
      d.rd_snap = (address == `STATUS_OFS) ? q.status : 2'h0;
    end
    if (accept && write) begin
      if (address == `CTRL_OFS && byteenable[0]) begin
        d.ctrl = writedata[`CTRL_WIDTH-1:0];
      end
      if (address == `MASK_OFS && byteenable[0]) begin
        d.mask = writedata[`ST_WIDTH-1:0];
      end
    end
    // strobe sense from the incoming control word, no false edge on a change
    d.strobe_out = d.strobe_lvl ^ d.ctrl[`CTRL_POL_BIT];
    if (accept && read) begin
      clr = q.rd_snap;
    end
    // sticky events, set wins over the read clear
    evt[`ST_SAMPLE_BIT] = latch_evt;
    evt[`ST_OVER_BIT]   = latch_evt && over_raw;
    d.status = (q.status & ~clr) | evt;
    d.irq    = |(d.status & d.mask);
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign readdata          = q.rdata;
  assign waitrequest       = q.waitreq;
  assign result_bits       = q.data_out;
  assign overrange_flag    = q.over;
  assign data_valid_strobe = q.strobe_out;
  assign irq               = q.irq;

  // sample taken at the rising phase with a given input level
  sequence s_sample(logic [8:0] v);
    ctrl_en && (q.phase == PH_TRACK) && (q.in_sync == v);
  endsequence

  // converter left running through decode and output latch
  sequence s_run;
    ##1 ctrl_en ##1 (ctrl_en && flip == 8'h00);
  endsequence

  // input at the top of the range
  a_top_code: assert property (@(posedge ref_clk) disable iff (srst)
    (s_sample(9'h0FF) ##0 q.cols_ok) ##0 s_run |=> result_bits == 8'hFF && !overrange_flag)
    else $error("top of range did not give all ones");

  // input at the bottom of the range
  a_bottom_code: assert property (@(posedge ref_clk) disable iff (srst)
    (s_sample(9'h000) ##0 q.cols_ok) ##0 s_run |=> result_bits == 8'h00)
    else $error("bottom of range did not give zeros");

  // input beyond range raises the flag after one conversion
  a_over_detect: assert property (@(posedge ref_clk) disable iff (srst)
    (s_sample(9'h1FF) ##0 q.cols_ok) ##0 s_run |=> overrange_flag && result_bits == 8'hFF)
    else $error("overrange not flagged");

  // flag always comes with all ones on the data
  a_over_forces: assert property (@(posedge ref_clk) disable iff (srst)
    overrange_flag |-> result_bits == 8'hFF)
    else $error("overrange without forced ones");

  // comparator word is a thermometer code
  a_therm_shape: assert property (@(posedge ref_clk) disable iff (srst)
    q.comp_ok |-> ((q.comp & (q.comp + 256'h1)) == '0))
    else $error("comparator word is not a thermometer");

  // low invert touches only bits 0 to 6
  a_low_invert: assert property (@(posedge ref_clk) disable iff (srst)
    ($past(latch_evt) && !overrange_flag) |->
      result_bits[6:0] == (q.plain[6:0] ^ {7{$past(low_bits_invert_ctl)}}))
    else $error("low bits not inverted as selected");

  // msb invert touches only bit 7
  a_msb_invert: assert property (@(posedge ref_clk) disable iff (srst)
    ($past(latch_evt) && !overrange_flag) |->
      result_bits[7] == (q.plain[7] ^ $past(msb_invert_ctl)))
    else $error("msb not inverted as selected");

  // strobe active for the latch cycle, idle on the next
  a_strobe_pulse: assert property (@(posedge ref_clk) disable iff (srst)
    (latch_evt && $stable(q.ctrl)) |=>
      (data_valid_strobe != valid_polarity_sel) ##1 (data_valid_strobe == valid_polarity_sel))
    else $error("ready strobe out of step with data");

  // no strobe before the pipeline has filled
  a_no_early: assert property (@(posedge ref_clk) disable iff (srst)
    (!q.cols_ok && !q.strobe_lvl) |=> !q.strobe_lvl || $past(latch_evt))
    else $error("ready strobe before first conversion");

  // conversion clock alternates while enabled
  a_phase_toggle: assert property (@(posedge ref_clk) disable iff (srst)
    (ctrl_en && $past(ctrl_en)) |-> q.phase != $past(q.phase))
    else $error("conversion phase stuck");

  // every bus request answered within one cycle
  a_bus_answer: assert property (@(posedge ref_clk) disable iff (srst)
    (req && waitrequest) |=> !waitrequest)
    else $error("waitrequest not released");

  // interrupt follows masked status
  a_irq_level: assert property (@(posedge ref_clk) disable iff (srst)
    irq == |(q.status & q.mask))
    else $error("interrupt disagrees with status");

  // outputs idle in the cycle after any reset edge
  a_reset_idle: assert property (@(posedge ref_clk)
    srst |=> result_bits == 8'h00 && !overrange_flag && !irq && waitrequest)
    else $error("outputs not idle after reset");

  // result and flag move only when the output latch loads
  a_result_hold: assert property (@(posedge ref_clk) disable iff (srst)
    (!$past(latch_evt) && !$past(srst)) |-> $stable(result_bits) && $stable(overrange_flag))
    else $error("result changed without a latch");

  // input level reaches the comparators through two flops
  a_input_sync: assert property (@(posedge ref_clk) disable iff (srst)
    (!$past(srst) && !$past(srst, 2)) |-> q.in_sync == $past(analog_input, 2))
    else $error("input synchroniser out of step");

  // comparators keep their decision through the hold phase
  a_comp_hold: assert property (@(posedge ref_clk) disable iff (srst)
    (q.phase == PH_HOLD) |=> $stable(q.comp))
    else $error("comparators changed while holding");

  // comparators never load while the converter is stopped
  a_stop_freeze: assert property (@(posedge ref_clk) disable iff (srst)
    !ctrl_en |=> $stable(q.comp))
    else $error("comparators loaded while stopped");

  // conversion clock parks in the tracking phase while stopped
  a_phase_park: assert property (@(posedge ref_clk) disable iff (srst)
    !$past(ctrl_en) |-> q.phase == PH_TRACK)
    else $error("conversion clock not parked");

  // strobe idles while the converter is stopped
  a_strobe_idle: assert property (@(posedge ref_clk) disable iff (srst)
    (!ctrl_en && !$past(ctrl_en)) |-> data_valid_strobe == valid_polarity_sel)
    else $error("strobe active while stopped");

  // a new sample is latched every second cycle while running
  a_latch_rate: assert property (@(posedge ref_clk) disable iff (srst)
    (latch_evt ##1 ctrl_en [*2]) |-> latch_evt)
    else $error("latch rate broken");

  // enable edge followed by the pipeline filling
  sequence s_enable_fill;
    $rose(ctrl_en) ##1 ctrl_en [*2];
  endsequence

  // no strobe until comparators and columns have filled
  a_fill_quiet: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(ctrl_en) |-> (data_valid_strobe == valid_polarity_sel) [*3])
    else $error("strobe before the pipeline filled");

  // first strobe once the pipeline is full
  a_first_strobe: assert property (@(posedge ref_clk) disable iff (srst)
    s_enable_fill |=> data_valid_strobe != valid_polarity_sel)
    else $error("first strobe missing");

  // accepted access returns waitrequest high
  a_bus_release: assert property (@(posedge ref_clk) disable iff (srst)
    (req && !waitrequest) |=> waitrequest)
    else $error("waitrequest held low");

endmodule : flash_adc_output_decode

// ### capture_model.sv
`timescale 1ns/10ps
module capture_model (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // converter outputs
  input  wire logic [7:0]  result_bits,
  input  wire logic        overrange_flag,
  input  wire logic        data_valid_strobe,
  input  wire logic        valid_polarity_sel,
  // last captured sample
  output logic      [7:0]  cap_data,
  output logic             cap_over,
  output logic      [15:0] cap_count
);
  // take data only while the strobe shows its active level
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cap_data  <= 8'h00;
      cap_over  <= 1'b0;
      cap_count <= 16'h0000;
    end else if (data_valid_strobe === ~valid_polarity_sel) begin
      cap_data  <= result_bits;
      cap_over  <= overrange_flag;
      cap_count <= cap_count + 16'h0001;
    end
  end
endmodule : capture_model

// ### tb.sv
`timescale 1ns/10ps
`include "flash_adc_defs.svh"
module tb;
  import flash_adc_pkg::*;
  typedef struct packed {
    logic [3:0] ctrl;
    logic [8:0] level;
    logic [7:0] code;
    logic       over;
  } row_t;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic [3:0]  address = 4'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0]  byteenable = 4'hF;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [8:0]  analog_input = 9'h000;
  logic [7:0]  result_bits;
  logic        overrange_flag;
  logic        data_valid_strobe;
  logic        irq;
  logic        pol_sel = 1'b0;
  logic [7:0]  cap_data;
  logic        cap_over;
  logic [15:0] cap_count;
  logic [31:0] q;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          c;
  // control, input level, expected code, expected overrange
  row_t rows [11] = '{
    '{4'h1, 9'h000, 8'h00, 1'b0}, '{4'h1, 9'h0FF, 8'hFF, 1'b0},
    '{4'h1, 9'h080, 8'h80, 1'b0}, '{4'h3, 9'h080, 8'hFF, 1'b0},
    '{4'h5, 9'h080, 8'h00, 1'b0}, '{4'h7, 9'h07F, 8'h80, 1'b0},
    '{4'h3, 9'h005, 8'h7A, 1'b0}, '{4'h7, 9'h12C, 8'hFF, 1'b1},
    '{4'h5, 9'h100, 8'hFF, 1'b1}, '{4'h1, 9'h1FF, 8'hFF, 1'b1},
    '{4'h9, 9'h04D, 8'h4D, 1'b0}};

  always #10 ref_clk = ~ref_clk;

  flash_adc_output_decode i_dut (.ref_clk(ref_clk), .srst(srst), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .analog_input(analog_input),
    .result_bits(result_bits), .overrange_flag(overrange_flag),
    .data_valid_strobe(data_valid_strobe), .irq(irq));

  capture_model i_cap (.ref_clk(ref_clk), .srst(srst), .result_bits(result_bits),
    .overrange_flag(overrange_flag), .data_valid_strobe(data_valid_strobe),
    .valid_polarity_sel(pol_sel), .cap_data(cap_data), .cap_over(cap_over),
    .cap_count(cap_count));

  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge ref_clk);
    address    <= a;
    read       <= ~wr;
    write      <= wr;
    writedata  <= d;
    byteenable <= be;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rd    = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      mismatches++;
      wrap_up();
    end
  endtask : bus

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
    bus(a, 1'b0, 32'h0, 4'hF, q);
    check(what, q, exp);
  endtask : rd_chk

  // wait for k further captured samples
  task automatic wait_samples(input int k);
    logic [15:0] s;
    int n;
    s = cap_count;
    n = 0;
    while (cap_count != s + 16'(k) && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 100) begin
      mismatches++;
      wrap_up();
    end
  endtask : wait_samples

  // cycles in 20 with the strobe at a given level
  task automatic count_lvl(input logic lvl, output int cnt);
    cnt = 0;
    repeat (20) begin
      @(negedge ref_clk);
      if (data_valid_strobe === lvl) cnt++;
    end
  endtask : count_lvl

  initial begin
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    @(negedge ref_clk);
    // idle state after reset
    check("result", {24'h0, result_bits}, 32'h0);
    check("flags", {28'h0, overrange_flag, data_valid_strobe, irq, waitrequest}, 32'h1);
    rd_chk(`CTRL_OFS, 32'h0, "ctrl reset");
    rd_chk(`STATUS_OFS, 32'h0, "status reset");
    rd_chk(`MASK_OFS, 32'h0, "mask reset");
    // table of codes
    foreach (rows[i]) begin
      bus(`CTRL_OFS, 1'b1, {28'h0, rows[i].ctrl}, 4'hF, q);
      pol_sel      <= rows[i].ctrl[3];
      analog_input <= rows[i].level;
      wait_samples(4);
      check("captured code", {24'h0, cap_data}, {24'h0, rows[i].code});
      check("captured over", {31'h0, cap_over}, {31'h0, rows[i].over});
      rd_chk(`RESULT_OFS, {23'h0, rows[i].over, rows[i].code}, "result reg");
    end
    // strobe polarity, one active cycle per conversion
    count_lvl(1'b0, c);
    check("strobe low count", 32'(c), 32'd10);
    bus(`CTRL_OFS, 1'b1, 32'h1, 4'hF, q);
    pol_sel <= 1'b0;
    repeat (6) @(negedge ref_clk);
    count_lvl(1'b1, c);
    check("strobe high count", 32'(c), 32'd10);
    // overrange, then stop and hold
    @(posedge ref_clk);
    analog_input <= 9'h12C;
    wait_samples(4);
    bus(`CTRL_OFS, 1'b1, 32'h0, 4'hF, q);
    analog_input <= 9'h005;
    repeat (10) @(negedge ref_clk);
    check("held result", {23'h0, overrange_flag, result_bits}, 32'h1FF);
    check("irq masked", {31'h0, irq}, 32'h0);
    // interrupt unmask, clear on read
    bus(`MASK_OFS, 1'b1, 32'h2, 4'hF, q);
    repeat (2) @(negedge ref_clk);
    check("irq over", {31'h0, irq}, 32'h1);
    bus(`MASK_OFS, 1'b1, 32'h1, 4'hF, q);
    repeat (2) @(negedge ref_clk);
    check("irq sample", {31'h0, irq}, 32'h1);
    rd_chk(`STATUS_OFS, 32'h3, "status");
    @(negedge ref_clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    rd_chk(`STATUS_OFS, 32'h0, "status cleared");
    // refused writes
    bus(`MASK_OFS, 1'b1, 32'h3, 4'h0, q);
    rd_chk(`MASK_OFS, 32'h1, "mask no lane");
    bus(`RESULT_OFS, 1'b1, 32'h0, 4'hF, q);
    rd_chk(`RESULT_OFS, 32'h1FF, "result ro");
    bus(4'h2, 1'b1, 32'hF, 4'hF, q);
    rd_chk(4'h2, 32'h0, "unmapped");
    // reset in mid-run returns everything to idle
    bus(`CTRL_OFS, 1'b1, 32'h1, 4'hF, q);
    wait_samples(2);
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(negedge ref_clk);
    check("reset result", {23'h0, overrange_flag, result_bits}, 32'h0);
    check("reset flags", {28'h0, overrange_flag, data_valid_strobe, irq, waitrequest}, 32'h1);
    rd_chk(`MASK_OFS, 32'h0, "mask after reset");
    rd_chk(`CTRL_OFS, 32'h0, "ctrl after reset");
    wrap_up();
  end
endmodule : tb
